/* File: flash_model.sv */
// Behavioural flash device: status register and read overlay
`timescale 1ns/1ps
module flash_model (
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire [15:0] flash_dq_out,
  output logic [15:0] flash_dq_in,
  output wire ready_busy_output
);
  logic [15:0] sr = 16'h0080;
  logic [7:0] cmd = 0, junk = 0;
  logic ovl = 0, rd = 0, tog = 0;
  initial flash_dq_in = 16'h0000;
  assign ready_busy_output = sr[7];
  // Latch the byte while the write strobe is low
  always @* if (!flash_we_n && !flash_ce_n) cmd = flash_dq_out[7:0];
  // Act at the end of the write pulse
  always @(posedge flash_we_n) case (cmd)
    8'h70: ovl = 1;
    8'h71: sr = sr & 16'hFFC4;
    8'h30: sr[6] = 0;
    8'h51: sr[2] = 0;
    default: ;
  endcase
  // Instant program or erase; result flags are cleared before it runs
  task automatic run_op(input logic prog, input logic locked);
    sr[5:3] = 3'b000;
    sr[1] = locked;
    if (prog && sr[6])
      sr[4] = 1'b1;
  endtask
  // Released bus shows the inverse, so no stale value passes
  always @(flash_ce_n or flash_oe_n)
    if (!flash_ce_n && !flash_oe_n) begin
      flash_dq_in = ovl ? {junk, sr[7], sr[7] ? sr[6:1] : junk[6:1],
        junk[0]} : 16'h5A5A;
      // Array read: datum bit 7 is 0, shown inverted while busy, with bit 6 toggling
      if (!ovl)
        flash_dq_in[7:6] = sr[7] ? 2'b01 : {1'b1, tog};
      rd = 1;
    end else begin
      flash_dq_in = ~flash_dq_in;
      if (rd && !ovl && !sr[7])
        tog = ~tog;
      if (rd) begin
        ovl = 0;
        junk = junk + 8'h3B;
      end
      rd = 0;
    end
endmodule // flash_model

/* File: flash_status_host.v */
// APB-controlled host that issues status reads to a parallel NOR flash
`timescale 1ns/1ps
`include "flash_status_regs.vh"
// What the device and this block do
// RULE1 - Device keeps a 16-bit status register for program and erase results.
// RULE2 - Host writes status-read command then performs exactly one read.
// RULE3 - Status appears at any address during that overlay read.
// RULE4 - Device leaves overlay after the single read.
// RULE5 - Host holds chip select and output enable high for the high time.
// RULE6 - Bits 15 to 8 are reserved; host masks them.
// RULE7 - Bit 7 reads 1 when idle, 0 while busy.
// RULE8 - Bits 6 to 1 valid only when ready; host disregards them when busy.
// RULE9 - Result flags: 1 fail, 0 pass; bits 5, 4, 3.
// RULE10 - Bit 6 erase suspended, bit 2 program suspended.
// RULE11 - Reset loads ready 1 and lower flags 0.
// RULE12 - Clear-status or reset clears bits 5, 4, 3, 1, 0.
// RULE13 - Starting an operation first clears status flags.
// RULE14 - Erase-resume clears the erase-suspended flag.
// RULE15 - Program-resume clears the program-suspended flag.
// RULE16 - After suspend, host reads status until ready returns 1.
// RULE17 - Program to an erase-suspended sector fails, sets program flag.
// RULE18 - Bit 1 flags a protected-sector failure of latest operation.
// RULE19 - Bit 0 is continuity pattern or reserved; host masks it.
// RULE20 - Device drives a ready/busy output.
// RULE21 - Data bits 7 and 6 show progress during array reads.
// RULE22 - Bit 7 returns inverse of programmed bit while programming.
// RULE23 - Bit 6 toggles on each read while an operation runs.
// RULE24 - Reserved bits 15 to 8 may be driven as zero.
module flash_status_host #(
  parameter WE_CYC = (`T_WE_LOW_NS + `CLK_NS - 1) / `CLK_NS,
  parameter ACC_CYC = (`T_ACC_NS + `CLK_NS - 1) / `CLK_NS,
  parameter HIGH_CYC = (`T_HIGH_NS + `CLK_NS - 1) / `CLK_NS
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [23:0] flash_addr,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [15:0] flash_dq_in,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  input wire ready_busy_output
);
  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_WR = 3'd1;
  localparam S_GAP = 3'd2;
  localparam S_RD = 3'd3;
  localparam S_DONE = 3'd4;
  localparam S_BACK = 3'd5;
  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg [7:0] cmd_q;
  reg rd_after_q;
  reg poll_q;
  reg busy_q;
  reg [15:0] last_q;
  reg [15:0] raw_q;
  reg [15:0] dq_s1_q, dq_s2_q, dq_s3_q;
  reg rb_s1_q, rb_s2_q, rb_s3_q, rb_q;
  reg [15:0] dq_q;
  wire apb_wr = psel & penable & pwrite & pready;
  wire go_req = apb_wr && paddr == `CTRL_OFF && !busy_q;

  // Three-stage pin sync; accept only when last two stages agree
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      dq_s3_q <= 16'h0000;
      dq_q <= 16'h0000;
      // Ready is the idle level, so no false busy after reset
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      rb_s3_q <= 1'b1;
      rb_q <= 1'b1;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
      rb_s1_q <= ready_busy_output;
      rb_s2_q <= rb_s1_q;
      rb_s3_q <= rb_s2_q;
      if (dq_s2_q == dq_s3_q)
        dq_q <= dq_s3_q;
      if (rb_s2_q == rb_s3_q)
        rb_q <= rb_s3_q; // RULE20
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero-wait, single-cycle pready during access
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel & ~penable) begin
        case (paddr)
          `CTRL_OFF: prdata <= {31'h00000000, busy_q};
          `STAT_OFF: prdata <= {23'h000000, cmd_q, rb_q};
          `LAST_OFF: prdata <= {16'h0000, last_q & `SR_MASK}; // RULE6 RULE19
          `RAW_OFF: prdata <= {16'h0000, raw_q};
          `POLL_OFF: prdata <= {31'h00000000, poll_q};
          default: pslverr <= 1'b1 & ~pwrite | pwrite;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash bus sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      cnt_q <= 8'h00;
      cmd_q <= 8'h00;
      rd_after_q <= 1'b0;
      poll_q <= 1'b0;
      busy_q <= 1'b0;
      last_q <= 16'h0080;
      raw_q <= 16'h0000;
      flash_addr <= 24'h000000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (go_req) begin
            busy_q <= 1'b1;
            poll_q <= pwdata[`CTRL_POLL_BIT]; // RULE16
            rd_after_q <= 1'b1;
            cmd_q <= `CMD_STATUS_READ; // RULE2
            if (pwdata[`CTRL_CLR_BIT]) begin
              cmd_q <= `CMD_CLEAR_STATUS; // RULE12
              rd_after_q <= 1'b0;
            end else if (pwdata[`CTRL_ERS_BIT]) begin
              cmd_q <= `CMD_ERASE_RESUME; // RULE14
              rd_after_q <= 1'b0;
            end else if (pwdata[`CTRL_PRS_BIT]) begin
              cmd_q <= `CMD_PROG_RESUME; // RULE15
              rd_after_q <= 1'b0;
            end
            cnt_q <= WE_CYC[7:0];
            state_q <= S_WR;
          end
        end
        S_WR: begin
          // Command write cycle
          flash_addr <= `CMD_ADDR;
          flash_dq_out <= {8'h00, cmd_q};
          flash_dq_oe <= 1'b1;
          flash_ce_n <= 1'b0;
          flash_we_n <= 1'b0;
          if (cnt_q == 8'h00) begin
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            cnt_q <= HIGH_CYC[7:0];
            state_q <= S_GAP;
          end else
            cnt_q <= cnt_q - 8'h01;
        end
        S_GAP: begin
          // Strobes stay high for the minimum high time
          flash_ce_n <= 1'b1; // RULE5
          flash_oe_n <= 1'b1; // RULE5
          if (cnt_q == 8'h00) begin
            if (rd_after_q) begin
              cnt_q <= ACC_CYC[7:0] + 8'h03;
              state_q <= S_RD;
            end else
              state_q <= S_DONE;
          end else
            cnt_q <= cnt_q - 8'h01;
        end
        S_RD: begin
          // One read only; any address serves, device exits overlay after
          flash_addr <= 24'h000000; // RULE3 RULE4
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b0;
          if (cnt_q == 8'h00) begin
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            raw_q <= dq_q;
            // Lower flags only meaningful when ready
            if (dq_q[`SR_READY_BIT])
              last_q <= {8'h00, dq_q[7:0]}; // RULE8 RULE24 RULE1
            else
              last_q <= {8'h00, 1'b0, last_q[6:0]}; // RULE7
            rd_after_q <= 1'b1;
            cmd_q <= `CMD_STATUS_READ;
            // Rest high before re-polling, or the next cycle comes too soon
            cnt_q <= HIGH_CYC[7:0];
            if (poll_q && !dq_q[`SR_READY_BIT])
              state_q <= S_BACK; // RULE16
            else
              state_q <= S_DONE;
          end else
            cnt_q <= cnt_q - 8'h01;
        end
        S_BACK: begin
          // Strobes rest high before the next command write
          if (cnt_q == 8'h00) begin
            cnt_q <= WE_CYC[7:0];
            state_q <= S_WR;
          end else
            cnt_q <= cnt_q - 8'h01; // RULE5
        end
        S_DONE: begin
          busy_q <= 1'b0;
          poll_q <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // flash_status_host

/* File: flash_status_host_monitor.sv */
// Port checker for the flash status host
`timescale 1ns/1ps
module flash_status_host_monitor #(
  parameter HIGH_CYC = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [23:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] hc_q;
  wire rd_last = pready && !pwrite && paddr == 12'h008;
  // Cycles with chip select high; saturates so idle never wraps
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) hc_q <= 8'h00;
    else if (!flash_ce_n) hc_q <= 8'h00;
    else if (hc_q != 8'hFF) hc_q <= hc_q + 8'h01;
  a_cmd_drive: assert property
    ($fell(flash_we_n) |-> flash_dq_oe && !flash_ce_n) else $error("cmd");
  a_no_fight: assert property
    (!flash_oe_n |-> !flash_dq_oe) else $error("fight");
  a_strobe_excl: assert property
    (flash_we_n || flash_oe_n) else $error("strobes");
  a_read_follows: assert property
    ($rose(flash_we_n) && $past(flash_dq_out[7:0]) == 8'h70
      |-> ##[1:20] $fell(flash_oe_n)) else $error("no read");
  a_read_ends: assert property
    ($fell(flash_oe_n) |-> ##[1:30] $rose(flash_oe_n)) else $error("stuck");
  a_high_time: assert property
    ($fell(flash_ce_n) |-> hc_q >= HIGH_CYC) else $error("short high");
  a_mask_bits: assert property
    (rd_last |-> prdata[31:8] == 0 && !prdata[0]) else $error("mask");
  a_apb_answer: assert property
    (psel && !penable |=> pready ##1 !pready) else $error("answer");
  a_bad_addr: assert property
    (pready && paddr > 12'h010 |-> pslverr) else $error("slverr");
  a_cmd_addr: assert property
    (!flash_we_n |-> flash_addr == 24'h000555) else $error("cmd addr");
endmodule // flash_status_host_monitor

/* File: flash_status_regs.vh */
// Constants for the flash status-read host controller
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH
// APB register offsets (byte addresses)
`define CTRL_OFF 12'h000
`define STAT_OFF 12'h004
`define LAST_OFF 12'h008
`define RAW_OFF 12'h00C
`define POLL_OFF 12'h010
// Control register bit positions
`define CTRL_GO_BIT 0
`define CTRL_POLL_BIT 1
`define CTRL_CLR_BIT 2
`define CTRL_ERS_BIT 3
`define CTRL_PRS_BIT 4
// Status register bit positions (device side)
`define SR_READY_BIT 7
`define SR_ESUSP_BIT 6
`define SR_EFAIL_BIT 5
`define SR_PFAIL_BIT 4
`define SR_ABORT_BIT 3
`define SR_PSUSP_BIT 2
`define SR_LOCK_BIT 1
`define SR_CONT_BIT 0
// Meaningful bits: 7..1 (15:8 and 0 are masked)
`define SR_MASK 16'h00FE
// Flash command bytes
`define CMD_STATUS_READ 8'h70
`define CMD_CLEAR_STATUS 8'h71
`define CMD_ERASE_RESUME 8'h30
`define CMD_PROG_RESUME 8'h51
`define CMD_ADDR 24'h000555
// Bus timings in ns
`define T_WE_LOW_NS 35
`define T_ACC_NS 70
`define T_HIGH_NS 20
`define CLK_NS 8
`endif

/* File: testbench.sv */
// Self-checking bench for the flash status host
`timescale 1ns/1ps
`include "flash_status_regs.vh"
module testbench;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, seed = 32'h4CF95065;
  logic pready, pslverr, flash_dq_oe, flash_ce_n, flash_oe_n;
  logic flash_we_n, ready_busy_output;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic [23:0] flash_addr;
  int mismatches = 0, n_checks = 0, cyc = 0, last;
  flash_status_host i_flash_status_host (.*);
  flash_model i_flash_model (.*);
  always #4 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] s, x);
    n_checks++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %0t %h %h", $time, s, x);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Control write, then poll busy until clear
  task automatic op(input int c);
    apb(1, 12'h000, c);
    repeat (2) @(posedge clk);
    do apb(0, 12'h000, 0); while (r[0] !== 1'b0);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    apb(0, 12'h008, 0);
    chk(r, 32'h80);
    apb(0, 12'h004, 0);
    chk(r[0], 1);
    // Random flags; the last two reads find the device busy
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      i_flash_model.sr = {seed[15:8], i < 10, seed[6:0]};
      last = i < 10 ? (seed & 'h7E) | 'h80 : last & 'h7E;
      op(1);
      apb(0, 12'h008, 0);
      chk(r, last);
      apb(0, 12'h00C, 0);
      chk(r[7], i < 10);
    end
    i_flash_model.sr = 16'h00FF;
    last = 'hFE;
    for (int k = 2; k < 5; k++) begin
      op(1 << k);
      apb(0, 12'h004, 0);
      chk(r[8:1], k == 2 ? `CMD_CLEAR_STATUS : k == 3 ?
        `CMD_ERASE_RESUME : `CMD_PROG_RESUME);
      op(1);
      apb(0, 12'h008, 0);
      last &= k == 2 ? 'hC4 : k == 3 ? 'hBF : 'hFB;
      chk(r, last);
    end
    // Operations run in the device: erase suspended, then a locked sector
    i_flash_model.sr = 16'h00F8;
    i_flash_model.run_op(1, 0);
    op(1);
    apb(0, 12'h008, 0);
    chk(r, 32'hD0);
    i_flash_model.run_op(0, 1);
    op(1);
    apb(0, 12'h008, 0);
    chk(r, 32'hC2);
    // Polling must keep going while busy and stop once ready
    i_flash_model.sr = 16'h0004;
    apb(1, 12'h000, 3);
    repeat (200) @(posedge clk);
    apb(0, 12'h010, 0);
    chk(r[0], 1);
    i_flash_model.sr = 16'h0084;
    do apb(0, 12'h000, 0); while (r[0] !== 1'b0);
    apb(0, 12'h008, 0);
    chk(r, 32'h84);
    apb(0, 12'h010, 0);
    chk(r[0], 0);
    // Reset while idle: host state returns to its reset values
    sys_rst <= 1;
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    apb(0, 12'h008, 0);
    chk(r, 32'h80);
    op(1);
    apb(0, 12'h008, 0);
    chk(r, 32'h84);
    apb(1, 12'h020, seed);
    chk(e, 1);
    print_verdict;
  end
endmodule // testbench
bind flash_status_host flash_status_host_monitor #(.HIGH_CYC(HIGH_CYC))
  i_mon (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n));
